/* File: hw/sam_pkg.sv */
// constants for the sdram address multiplexer
// What this block does
// - 9-bit column: row phase drives pin n with internal bit n+9, pins 0..17
// - 9-bit column: column phase drives pins 0-10, 12, 15-17 with same bits
// - 9-bit column: pins 14/13 carry A23/A22 in both phases as bank selects
// - column phase pin 11 carries the command level bit, set by the control register level bit
// - 10-bit column: row phase drives pin n with internal bit n+10, pins 0..17
// - 10-bit column: pins 14/13 carry A24/A23 in both phases as bank selects
// - 10-bit column: pin 11 is A21 in row phase, level bit in column phase
package sam_pkg;
  localparam int ADDR_W = 28;
  localparam int PIN_W = 18;
  localparam int REG_AW = 8;
  localparam int DATA_W = 32;

  // register offsets
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_CNT = 8'h0C;
  localparam logic [7:0] REG_ROWPIN = 8'h10;
  localparam logic [7:0] REG_COLPIN = 8'h14;

  // register field positions
  localparam int BSZ_LSB = 0;
  localparam int ROW_LSB = 2;
  localparam int COL_LSB = 4;
  localparam int CTRL_LH_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CFG_OK_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;
  localparam int STAT_COL10_BIT = 3;
  localparam int STAT_BANK_LSB = 4;

  // field encodings
  localparam logic [1:0] BSZ_16 = 2'h2;
  localparam logic [1:0] ROW_12 = 2'h1;
  localparam logic [1:0] COL_9 = 2'h1;
  localparam logic [1:0] COL_10 = 2'h2;

  // reset values
  localparam logic [1:0] BSZ_RST = BSZ_16;
  localparam logic [1:0] ROW_RST = ROW_12;
  localparam logic [1:0] COL_RST = COL_9;
  localparam logic CTRL_LH_RST = 1'b0;

  // pin positions and row phase shifts
  localparam int PIN_LH = 11;
  localparam int PIN_BA0 = 13;
  localparam int PIN_BA1 = 14;
  localparam int ROW_SHIFT_9 = 9;
  localparam int ROW_SHIFT_10 = 10;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TRCD_NS = 20;
  localparam int TRCD_CYC = (TRCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
                            (TRCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 4;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACT,
    ST_WAIT,
    ST_COL,
    ST_DONE
  } sam_state_t;
endpackage

/* File: hw/sam_pin_map.sv */
// pin word for the row or column phase
`timescale 1ns/10ps
module sam_pin_map (
  input wire logic [sam_pkg::ADDR_W-1:0] addr,
  input wire logic col10,
  input wire logic row_phase,
  input wire logic lh_level,
  output logic [sam_pkg::PIN_W-1:0] pins
);
  import sam_pkg::*;

  logic [ADDR_W+ROW_SHIFT_10-1:0] ext;

  assign ext = {{ROW_SHIFT_10{1'b0}}, addr};

  always_comb begin
    pins = '0;
    if (row_phase) begin
      if (col10) begin
        pins = ext[ROW_SHIFT_10 +: PIN_W];
      end else begin
        pins = ext[ROW_SHIFT_9 +: PIN_W];
      end
    end else begin
      pins = addr[PIN_W-1:0];
      if (col10) begin
        pins[PIN_BA0] = addr[23];
        pins[PIN_BA1] = addr[24];
      end else begin
        pins[PIN_BA0] = addr[22];
        pins[PIN_BA1] = addr[23];
      end
      pins[PIN_LH] = lh_level;
    end
  end
endmodule

/* File: hw/sam_tmr.sv */
// down counter for command spacing
`timescale 1ns/10ps
module sam_tmr #(
  parameter int W = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic expired
);
  logic [W-1:0] cnt_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (load) begin
      cnt_ff <= value;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  assign expired = (cnt_ff == '0) && !load;
endmodule

/* File: hw/sam_mux.sv */
// sdram address multiplexer with activate and column sequencing
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/10ps
module sam_mux #(
  parameter int ADDR_WIDTH = sam_pkg::ADDR_W,
  parameter int TRCD_CYCLES = sam_pkg::TRCD_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [sam_pkg::REG_AW-1:0] reg_addr,
  input wire logic [sam_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [sam_pkg::DATA_W-1:0] reg_rdata,
  input wire logic req_valid,
  input wire logic [sam_pkg::ADDR_W-1:0] req_addr,
  input wire logic req_write,
  output logic req_ready,
  output logic done_pulse,
  output logic [sam_pkg::PIN_W-1:0] sd_addr,
  output logic sd_cs_n,
  output logic sd_ras_n,
  output logic sd_cas_n,
  output logic sd_we_n
);
  import sam_pkg::*;

  // elaboration checks
  if (ADDR_WIDTH != ADDR_W) begin : g_bad_aw
    $error("address width must match the pin map");
  end
  if (TRCD_CYCLES < 1 || TRCD_CYCLES >= (1 << TMR_W)) begin : g_bad_trcd
    $error("activate to column spacing out of range");
  end

  // decode of a supported area setting
  function automatic logic cfg_supported(input logic [1:0] bsz, input logic [1:0] row,
                                         input logic [1:0] col);
    cfg_supported = (bsz == BSZ_16) && (row == ROW_12) && ((col == COL_9) || (col == COL_10));
  endfunction

  // configuration registers
  logic [1:0] area_bus_width_field_ff;
  logic [1:0] row_bits_field_ff;
  logic [1:0] column_bits_field_ff;
  logic lh_level_ff;

  // request latch and sequencer
  sam_state_t state_ff;
  sam_state_t nxt_state;
  logic [ADDR_W-1:0] addr_ff;
  logic write_ff;
  logic col10_ff;
  logic lh_req_ff;
  logic refused_ff;
  logic [15:0] act_cnt_ff;
  logic [PIN_W-1:0] row_pins_ff;
  logic [PIN_W-1:0] col_pins_ff;

  // pin and command outputs
  logic [PIN_W-1:0] sd_addr_ff;
  logic sd_cs_n_ff;
  logic sd_ras_n_ff;
  logic sd_cas_n_ff;
  logic sd_we_n_ff;
  logic done_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;

  logic cfg_ok;
  logic accept;
  logic tmr_load;
  logic tmr_expired;
  logic [PIN_W-1:0] row_word;
  logic [PIN_W-1:0] col_word;

  assign cfg_ok = cfg_supported(area_bus_width_field_ff, row_bits_field_ff, column_bits_field_ff);
  assign req_ready = (state_ff == ST_IDLE) && cfg_ok;
  assign accept = req_valid && req_ready;

  // register writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      area_bus_width_field_ff <= BSZ_RST;
      row_bits_field_ff <= ROW_RST;
      column_bits_field_ff <= COL_RST;
    end else if (reg_wr && reg_addr == REG_CFG) begin
      area_bus_width_field_ff <= reg_wdata[BSZ_LSB +: 2];
      row_bits_field_ff <= reg_wdata[ROW_LSB +: 2];
      column_bits_field_ff <= reg_wdata[COL_LSB +: 2];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lh_level_ff <= CTRL_LH_RST;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      lh_level_ff <= reg_wdata[CTRL_LH_BIT];
    end
  end

  // sticky refusal of requests under an unsupported setting
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      refused_ff <= 1'b0;
    end else if (req_valid && state_ff == ST_IDLE && !cfg_ok) begin
      refused_ff <= 1'b1;
    end else if (reg_wr && reg_addr == REG_STAT && reg_wdata[STAT_REFUSED_BIT]) begin
      refused_ff <= 1'b0;
    end
  end

  // activate counter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      act_cnt_ff <= 16'h0000;
    end else if (state_ff == ST_ACT) begin
      act_cnt_ff <= act_cnt_ff + 16'h0001;
    end else if (reg_wr && reg_addr == REG_CNT) begin
      act_cnt_ff <= 16'h0000;
    end
  end

  // request latch, one address serves both phases
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_ff <= '0;
      write_ff <= 1'b0;
      col10_ff <= 1'b0;
      lh_req_ff <= 1'b0;
    end else if (accept) begin
      addr_ff <= req_addr;
      write_ff <= req_write;
      col10_ff <= (column_bits_field_ff == COL_10);
      lh_req_ff <= lh_level_ff;
    end
  end

  sam_pin_map u_row_map (
    .addr(addr_ff),
    .col10(col10_ff),
    .row_phase(1'b1),
    .lh_level(lh_req_ff),
    .pins(row_word)
  );

  sam_pin_map u_col_map (
    .addr(addr_ff),
    .col10(col10_ff),
    .row_phase(1'b0),
    .lh_level(lh_req_ff),
    .pins(col_word)
  );

  assign tmr_load = (state_ff == ST_ACT);

  sam_tmr #(
    .W(TMR_W)
  ) u_trcd (
    .clock(clock),
    .rst(rst),
    .load(tmr_load),
    .value(TMR_W'(TRCD_CYCLES - 1)),
    .expired(tmr_expired)
  );

  // sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          nxt_state = ST_ACT;
        end
      end
      ST_ACT: begin
        nxt_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (tmr_expired) begin
          nxt_state = ST_COL;
        end
      end
      ST_COL: begin
        nxt_state = ST_DONE;
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // pins and command lines, pin 0 and pins 15..17 driven though unconnected
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sd_addr_ff <= '0;
      sd_cs_n_ff <= 1'b1;
      sd_ras_n_ff <= 1'b1;
      sd_cas_n_ff <= 1'b1;
      sd_we_n_ff <= 1'b1;
    end else begin
      sd_cs_n_ff <= 1'b1;
      sd_ras_n_ff <= 1'b1;
      sd_cas_n_ff <= 1'b1;
      sd_we_n_ff <= 1'b1;
      if (state_ff == ST_ACT) begin
        sd_addr_ff <= row_word;
        sd_cs_n_ff <= 1'b0;
        sd_ras_n_ff <= 1'b0;
      end else if (state_ff == ST_COL) begin
        sd_addr_ff <= col_word;
        sd_cs_n_ff <= 1'b0;
        sd_cas_n_ff <= 1'b0;
        sd_we_n_ff <= !write_ff;
      end
    end
  end

  // last words driven, kept for software
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      row_pins_ff <= '0;
      col_pins_ff <= '0;
    end else if (state_ff == ST_ACT) begin
      row_pins_ff <= row_word;
    end else if (state_ff == ST_COL) begin
      col_pins_ff <= col_word;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= (state_ff == ST_COL);
    end
  end

  // read decode
  always_comb begin
    nxt_rdata = '0;
    if (reg_addr == REG_CFG) begin
      nxt_rdata[BSZ_LSB +: 2] = area_bus_width_field_ff;
      nxt_rdata[ROW_LSB +: 2] = row_bits_field_ff;
      nxt_rdata[COL_LSB +: 2] = column_bits_field_ff;
    end else if (reg_addr == REG_CTRL) begin
      nxt_rdata[CTRL_LH_BIT] = lh_level_ff;
    end else if (reg_addr == REG_STAT) begin
      nxt_rdata[STAT_BUSY_BIT] = (state_ff != ST_IDLE);
      nxt_rdata[STAT_CFG_OK_BIT] = cfg_ok;
      nxt_rdata[STAT_REFUSED_BIT] = refused_ff;
      nxt_rdata[STAT_COL10_BIT] = col10_ff;
      nxt_rdata[STAT_BANK_LSB +: 2] = {row_pins_ff[PIN_BA1], row_pins_ff[PIN_BA0]};
    end else if (reg_addr == REG_CNT) begin
      nxt_rdata[15:0] = act_cnt_ff;
    end else if (reg_addr == REG_ROWPIN) begin
      nxt_rdata[PIN_W-1:0] = row_pins_ff;
    end else if (reg_addr == REG_COLPIN) begin
      nxt_rdata[PIN_W-1:0] = col_pins_ff;
    end
  end

  // read data stand one cycle after the strobe only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_ff <= '0;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= '0;
    end
  end

  assign reg_rdata = rdata_ff;
  assign done_pulse = done_ff;
  assign sd_addr = sd_addr_ff;
  assign sd_cs_n = sd_cs_n_ff;
  assign sd_ras_n = sd_ras_n_ff;
  assign sd_cas_n = sd_cas_n_ff;
  assign sd_we_n = sd_we_n_ff;
endmodule

/* File: sim/sam_mux_checker.sv */
// assertions on the pin words and command order of the address multiplexer
`timescale 1ns/10ps
module sam_mux_checker #(
  parameter int TRCD_CYCLES = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic req_valid,
  input wire logic [27:0] req_addr,
  input wire logic req_write,
  input wire logic req_ready,
  input wire logic done_pulse,
  input wire logic [17:0] sd_addr,
  input wire logic sd_cs_n,
  input wire logic sd_ras_n,
  input wire logic sd_cas_n,
  input wire logic sd_we_n
);
  import sam_pkg::*;
  // activate to column spacing as the sequencer runs it: timer load cycle plus the count
  localparam int COL_GAP = TRCD_CYCLES + 1;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic c10_set_ff, lh_set_ff, c10_ff, lh_ff, wr_ff, act, colc, take;
  logic [27:0] a_ff;
  assign act = !sd_cs_n && !sd_ras_n && sd_cas_n;
  assign colc = !sd_cs_n && sd_ras_n && !sd_cas_n;
  assign take = req_valid && req_ready;
  // setting and level bit as software wrote them
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      c10_set_ff <= 1'b0;
      lh_set_ff <= 1'b0;
    end else if (reg_wr && reg_addr == REG_CFG) begin
      c10_set_ff <= reg_wdata[COL_LSB+:2] == COL_10;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      lh_set_ff <= reg_wdata[CTRL_LH_BIT];
    end
  end
  // request captured when taken
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      a_ff <= 28'h0;
      c10_ff <= 1'b0;
      lh_ff <= 1'b0;
      wr_ff <= 1'b0;
    end else if (take) begin
      a_ff <= req_addr;
      c10_ff <= c10_set_ff;
      lh_ff <= lh_set_ff;
      wr_ff <= req_write;
    end
  end
  property p_row9;
    act && !c10_ff |-> sd_addr == a_ff[26:9];
  endproperty
  a_row9: assert property (p_row9) else $error("row word wrong, 9-bit column");
  property p_row10;
    act && c10_ff |-> sd_addr == a_ff[27:10];
  endproperty
  a_row10: assert property (p_row10) else $error("row word wrong, 10-bit column");
  property p_col9;
    colc && !c10_ff |-> sd_addr == {a_ff[17:15], a_ff[23:22], a_ff[12], lh_ff, a_ff[10:0]};
  endproperty
  a_col9: assert property (p_col9) else $error("column word wrong, 9-bit column");
  property p_col10;
    colc && c10_ff |-> sd_addr == {a_ff[17:15], a_ff[24:23], a_ff[12], lh_ff, a_ff[10:0]};
  endproperty
  a_col10: assert property (p_col10) else $error("column word wrong, 10-bit column");
  property p_seq;
    take |-> ##2 act ##COL_GAP colc && done_pulse;
  endproperty
  a_seq: assert property (p_seq) else $error("activate and column command out of order");
  property p_bank;
    colc |-> sd_addr[14:13] == $past(sd_addr[14:13], TRCD_CYCLES);
  endproperty
  a_bank: assert property (p_bank) else $error("column command to another bank");
  property p_we;
    colc |-> sd_we_n == !wr_ff;
  endproperty
  a_we: assert property (p_we) else $error("read or write command wrong");
  property p_done;
    done_pulse |-> colc ##1 req_ready;
  endproperty
  a_done: assert property (p_done) else $error("done without column command");
endmodule
bind sam_mux sam_mux_checker #(.TRCD_CYCLES(TRCD_CYCLES)) chk_u (.clock(clock), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .req_valid(req_valid),
  .req_addr(req_addr), .req_write(req_write), .req_ready(req_ready), .done_pulse(done_pulse),
  .sd_addr(sd_addr), .sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n), .sd_we_n(sd_we_n));

/* File: sim/sam_sdram_model.sv */
// sdram chip model recording opened rows and column accesses
`timescale 1ns/10ps
module sam_sdram_model (
  input wire logic clock,
  input wire logic [17:0] sd_addr,
  input wire logic sd_cs_n,
  input wire logic sd_ras_n,
  input wire logic sd_cas_n,
  input wire logic sd_we_n,
  output logic acc_v,
  output logic [28:0] acc_word
);
  logic [11:0] row_ff;
  logic [1:0] bank_ff;
  always @(posedge clock) begin
    acc_v <= 1'b0;
    if (!sd_cs_n && !sd_ras_n && sd_cas_n) begin
      row_ff <= sd_addr[12:1];
      bank_ff <= sd_addr[14:13];
    end
    if (!sd_cs_n && sd_ras_n && !sd_cas_n) begin
      acc_v <= 1'b1;
      acc_word <= {row_ff, bank_ff, sd_addr[14:13], sd_addr[12:1], !sd_we_n};
    end
  end
endmodule

/* File: sim/sam_mux_bench.sv */
// testbench for the sdram address multiplexer
`timescale 1ns/10ps
module sam_mux_bench;
  import sam_pkg::*;
  logic clock, rst, reg_wr, reg_rd, req_valid, req_write, req_ready, done_pulse, acc_v, rd_seen;
  logic sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [27:0] req_addr, a;
  logic [17:0] sd_addr;
  logic [28:0] acc_word;
  logic [28:0] acc_q[$];
  logic [63:0] rd_q[$];
  logic [63:0] note;
  int num_errors = 0;
  int num_checks = 0;
  sam_mux dut_u (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
    .req_addr(req_addr), .req_write(req_write), .req_ready(req_ready), .done_pulse(done_pulse),
    .sd_addr(sd_addr), .sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n), .sd_we_n(sd_we_n));
  sam_sdram_model mem_u (.clock(clock), .sd_addr(sd_addr), .sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n),
    .sd_cas_n(sd_cas_n), .sd_we_n(sd_we_n), .acc_v(acc_v), .acc_word(acc_word));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
    rd_q.push_back({m, e});
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask
  task automatic acc(input logic [27:0] ad, input logic w, input logic c10, input logic lh);
    int n;
    acc_q.push_back(c10 ? {ad[22:11], ad[24:23], ad[24:23], ad[12], lh, ad[10:1], w} :
      {ad[21:10], ad[23:22], ad[23:22], ad[12], lh, ad[10:1], w});
    @(posedge clock);
    req_valid <= 1'b1;
    req_addr <= ad;
    req_write <= w;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    @(posedge clock);
    req_valid <= 1'b0;
    do begin
      @(negedge clock);
      n++;
    end while (done_pulse !== 1'b1 && n < 100);
    if (n >= 100) begin
      num_errors++;
      $display("[FAIL] %0t access never finished", $time);
    end
  endtask
  // result monitor
  always @(negedge clock) begin
    if (acc_v === 1'b1) begin
      if (acc_q.size() == 0) begin
        num_errors++;
        $display("[FAIL] %0t unexpected memory access", $time);
      end else begin
        chk({3'h0, acc_word}, {3'h0, acc_q.pop_front()});
      end
    end
    if (rd_seen === 1'b1) begin
      note = rd_q.pop_front();
      chk(reg_rdata & note[63:32], note[31:0]);
    end
    rd_seen = reg_rd;
  end
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #200000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
  initial begin
    void'($urandom(88326));
    {rst, reg_wr, reg_rd, req_valid, req_write, rd_seen} = 6'h20;
    {reg_addr, reg_wdata, req_addr} = '0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd(REG_CFG, 32'hFFFFFFFF, 32'h16);
    rd(8'hFC, 32'hFFFFFFFF, 32'h0);
    for (int i = 0; i < 12; i++) begin
      if (i == 6) wr(REG_CFG, 32'h26);
      a = 28'($urandom);
      wr(REG_CTRL, 32'(i % 2));
      acc(a, i[1], i >= 6, i[0]);
    end
    rd(REG_CNT, 32'h0000FFFF, 32'hC);
    wr(REG_CFG, 32'h06);
    @(posedge clock);
    req_valid <= 1'b1;
    repeat (4) @(negedge clock);
    chk({31'h0, req_ready}, 32'h0);
    @(posedge clock);
    req_valid <= 1'b0;
    rd(REG_STAT, 32'h4, 32'h4);
    wr(REG_STAT, 32'h4);
    rd(REG_STAT, 32'h4, 32'h0);
    wr(REG_CFG, 32'h16);
    acc(28'hFFFFFFF, 1'b1, 1'b0, 1'b1);
    rd(REG_STAT, 32'h3F, 32'h32);
    rd(REG_ROWPIN, 32'h3FFFF, 32'h3FFFF);
    rd(REG_COLPIN, 32'h3FFFF, 32'h3FFFF);
    rd(REG_CNT, 32'h0000FFFF, 32'hD);
    wr(REG_CNT, 32'h0);
    rd(REG_CNT, 32'h0000FFFF, 32'h0);
    repeat (3) @(posedge clock);
    chk(32'(acc_q.size() + rd_q.size()), 32'h0);
    final_report();
  end
endmodule
